/* pkg/tccoc_map.svh */
// register indexes, field positions, reset values and codes of the timer block
`ifndef TCCOC_MAP_SVH
`define TCCOC_MAP_SVH
`define TCCOC_IDX_TMC 16'hff86
`define TCCOC_IDX_PRM 16'hff87
`define TCCOC_IDX_CRC 16'hff88
`define TCCOC_IDX_TOC 16'hff89
`define TCCOC_IDX_CCA 16'hff8a
`define TCCOC_IDX_CCB 16'hff8b
`define TCCOC_TMC_RUN 3:2
`define TCCOC_TMC_OVF 0
`define TCCOC_PRM_BEDGE 7:6
`define TCCOC_PRM_AEDGE 5:4
`define TCCOC_PRM_CKS 1:0
`define TCCOC_PRM_MASK 8'hf3
`define TCCOC_CRC_BMODE 2
`define TCCOC_CRC_ATRIG 1
`define TCCOC_CRC_AMODE 0
`define TCCOC_TOC_OST 6
`define TCCOC_TOC_OSEL 5
`define TCCOC_TOC_INVB 4
`define TCCOC_TOC_LVS 3
`define TCCOC_TOC_LVR 2
`define TCCOC_TOC_INVA 1
`define TCCOC_TOC_TOE 0
`define TCCOC_RST_8 8'h00
`define TCCOC_RST_16 16'h0000
`define TCCOC_RUN_STOP 2'h0
`define TCCOC_RUN_FREE 2'h1
`define TCCOC_RUN_CLR_EDGE 2'h2
`define TCCOC_RUN_CLR_MATCH 2'h3
`define TCCOC_EDGE_FALL 2'h0
`define TCCOC_EDGE_RISE 2'h1
`define TCCOC_EDGE_BOTH 2'h3
`define TCCOC_CKS_FULL 2'h0
`define TCCOC_CKS_DIV4 2'h1
`define TCCOC_CKS_DIV256 2'h2
`define TCCOC_DIV4_MASK 8'h03
`define TCCOC_DIV256_MASK 8'hff
`define TCCOC_CNT_TOP 16'hffff
`define TCCOC_RESP_OKAY 2'h0
`define TCCOC_RESP_SLVERR 2'h2
`endif

/* pkg/tccoc_pkg.sv */
// types shared by the timer capture/compare block
package tccoc_pkg;
    typedef enum logic [2:0] {
        reg_tmc = 3'h0,
        reg_prm = 3'h1,
        reg_crc = 3'h2,
        reg_toc = 3'h3,
        reg_cca = 3'h4,
        reg_ccb = 3'h5,
        reg_none = 3'h7
    } tccoc_reg_e;

    typedef struct packed {
        logic [17:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [17:0] araddr;
        logic arvalid;
        logic rready;
    } tccoc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tccoc_axi_rsp_s;

    typedef struct packed {
        logic prev;
    } tccoc_edge_s;

    typedef struct packed {
        logic [1:0] run;
        logic ovf;
        logic [7:0] prm;
        logic [2:0] crc;
        logic osel;
        logic invb;
        logic inva;
        logic toe;
        logic [15:0] cnt;
        logic [15:0] cca;
        logic [15:0] ccb;
        logic [7:0] div;
        logic lvl;
        logic armed;
        logic irq_a;
        logic irq_b;
        logic wave;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic [15:0] waddr;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [15:0] rdata;
    } tccoc_state_s;
endpackage : tccoc_pkg

/* tb/tccoc_pins.sv */
// model of the external pins that feed the two timer edge inputs
module tccoc_pins (
    input wire logic clk_in,
    output logic edge_input_a_out,
    output logic edge_input_b_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        edge_input_a_out = 1'h0;
        edge_input_b_out = 1'h0;
    end
    // one full pulse on a pin, each level held four clocks
    task automatic pulse(input logic sel_b);
        repeat (2) begin
            @(posedge clk_in);
            if (sel_b) edge_input_b_out <= ~edge_input_b_out;
            else edge_input_a_out <= ~edge_input_a_out;
            repeat (3) @(posedge clk_in);
        end
    endtask : pulse
endmodule : tccoc_pins

/* tb/test_timer_capture_compare_output_ctrl.sv */
// self-checking bench for the timer capture/compare and output control block
`include "tccoc_map.svh"
module test_timer_capture_compare_output_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'h0;
    logic nrst_in = 1'h0;
    tccoc_pkg::tccoc_axi_req_s req = '0;
    tccoc_pkg::tccoc_axi_rsp_s rsp;
    logic pin_a;
    logic pin_b;
    logic wave;
    logic irq_a;
    logic irq_b;
    int err_total = 0;
    int n_checks = 0;
    logic [15:0] rd;
    logic [1:0] resp;
    int na;
    int w;
    int lo[4] = '{0, 1, 2, 6};
    int hi[4] = '{0, 1, 2, 8};
    always #50 clk_in = ~clk_in;
    tccoc_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .axi_req_in(req), .axi_rsp_out(rsp),
        .edge_input_a_in(pin_a), .edge_input_b_in(pin_b), .wave_out_out(wave),
        .match_a_irq_out(irq_a), .match_b_irq_out(irq_b));
    tccoc_pins i_pins (.clk_in(clk_in), .edge_input_a_out(pin_a), .edge_input_b_out(pin_b));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        int i;
        @(posedge clk_in);
        req.awaddr <= {idx, 2'h0};
        req.awvalid <= 1'h1;
        req.wdata <= {16'h0000, d};
        req.wstrb <= 4'hf;
        req.wvalid <= 1'h1;
        req.bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'h0;
        resp = rsp.bresp;
        if (i == 50) err_total++;
    endtask : wr
    task automatic rd_reg(input logic [15:0] idx);
        int i;
        @(posedge clk_in);
        req.araddr <= {idx, 2'h0};
        req.arvalid <= 1'h1;
        req.rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'h0;
        rd = rsp.rdata[15:0];
        resp = rsp.rresp;
        if (i == 50) err_total++;
    endtask : rd_reg
    task automatic cnt(input int n);
        na = 0;
        repeat (n) begin
            @(posedge clk_in);
            if (irq_a === 1'h1) na++;
        end
    endtask : cnt
    task automatic wait_irq(input logic sel_b);
        for (w = 0; w < 200; w++) begin
            @(posedge clk_in);
            if ((sel_b ? irq_b : irq_a) === 1'h1) break;
        end
        chk("irq arrival", 16'h0001, 16'(w < 200));
    endtask : wait_irq
    task automatic wave_is(input logic exp);
        repeat (2) @(posedge clk_in);
        chk("wave", {15'h0000, exp}, {15'h0000, wave});
    endtask : wave_is
    task automatic cap(input logic [7:0] prm, input logic [7:0] crc, input logic sel_b,
                       input logic took, input int nirq);
        wr(`TCCOC_IDX_TMC, 16'h0000);
        wr(`TCCOC_IDX_PRM, {8'h00, prm});
        wr(`TCCOC_IDX_CRC, {8'h00, crc});
        wr(`TCCOC_IDX_CCA, 16'hffff);
        wr(`TCCOC_IDX_TMC, 16'h0004);
        cnt(4);
        fork
            i_pins.pulse(sel_b);
            cnt(12);
        join
        chk("capture irq", 16'(nirq), 16'(na));
        rd_reg(`TCCOC_IDX_CCA);
        chk("capture taken", {15'h0000, took}, {15'h0000, rd !== 16'hffff});
    endtask : cap
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    initial begin
        #(100 * 20000);
        err_total++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'h1;
        rd_reg(`TCCOC_IDX_CRC);
        chk("cc control reset", 16'h0000, rd);
        rd_reg(`TCCOC_IDX_TOC);
        chk("out control reset", 16'h0000, rd);
        wave_is(1'h0);
        wr(`TCCOC_IDX_CRC, 16'h00ff);
        rd_reg(`TCCOC_IDX_CRC);
        chk("cc control fields", 16'h0007, rd);
        wr(`TCCOC_IDX_TOC, 16'h0020);
        wr(`TCCOC_IDX_TOC, 16'h00f3);
        rd_reg(`TCCOC_IDX_TOC);
        chk("out control trigger bits", 16'h0033, rd);
        wr(16'hff90, 16'h0055);
        chk("unmapped write resp", 16'(`TCCOC_RESP_SLVERR), 16'(resp));
        rd_reg(16'hff90);
        chk("unmapped read resp", 16'(`TCCOC_RESP_SLVERR), 16'(resp));
        chk("unmapped read data", 16'h0000, rd);
        $display("test registers done");
        wr(`TCCOC_IDX_TOC, 16'h0012);
        wr(`TCCOC_IDX_TOC, 16'h0013);
        wr(`TCCOC_IDX_TOC, 16'h001b);
        wave_is(1'h1);
        wr(`TCCOC_IDX_TOC, 16'h0013);
        wave_is(1'h1);
        wr(`TCCOC_IDX_TOC, 16'h0017);
        wave_is(1'h0);
        wr(`TCCOC_IDX_TOC, 16'h001b);
        wr(`TCCOC_IDX_TOC, 16'h0012);
        wave_is(1'h0);
        $display("test output levels done");
        wr(`TCCOC_IDX_CRC, 16'h0000);
        wr(`TCCOC_IDX_CCA, 16'h0040);
        wr(`TCCOC_IDX_CCB, 16'h0080);
        wr(`TCCOC_IDX_TOC, 16'h0015);
        wr(`TCCOC_IDX_TMC, 16'h0004);
        wait_irq(1'h0);
        wave_is(1'h0);
        wait_irq(1'h1);
        wave_is(1'h1);
        wr(`TCCOC_IDX_TMC, 16'h0000);
        $display("test compare match done");
        wr(`TCCOC_IDX_TOC, 16'h0033);
        wr(`TCCOC_IDX_TOC, 16'h0037);
        wr(`TCCOC_IDX_TMC, 16'h0004);
        wait_irq(1'h0);
        wave_is(1'h0);
        repeat (10) @(posedge clk_in);
        wr(`TCCOC_IDX_TOC, 16'h0073);
        wait_irq(1'h0);
        wave_is(1'h1);
        rd_reg(`TCCOC_IDX_TOC);
        chk("one-shot trigger reads zero", 16'h0033, rd);
        wait_irq(1'h1);
        wave_is(1'h0);
        $display("test one-shot done");
        cap(8'h50, 8'h01, 1'h1, 1'h1, 1);
        cap(8'h50, 8'h03, 1'h1, 1'h0, 1);
        cap(8'h50, 8'h03, 1'h0, 1'h1, 1);
        cap(8'h70, 8'h03, 1'h0, 1'h0, 0);
        cap(8'h50, 8'h00, 1'h1, 1'h0, 0);
        $display("test capture done");
        wr(`TCCOC_IDX_TMC, 16'h0000);
        wr(`TCCOC_IDX_CRC, 16'h0000);
        wr(`TCCOC_IDX_TOC, 16'h0000);
        wr(`TCCOC_IDX_CCA, 16'h0010);
        for (int m = 0; m < 4; m++) begin
            wr(`TCCOC_IDX_TMC, 16'h0000);
            wr(`TCCOC_IDX_TMC, 16'(m << 2));
            fork
                cnt(120);
                begin
                    repeat (40) @(posedge clk_in);
                    i_pins.pulse(1'h0);
                end
            join
            chk("run mode irq count", 16'h0001, 16'(na >= lo[m] && na <= hi[m]));
        end
        $display("test run modes done");
        summarize();
    end
endmodule : test_timer_capture_compare_output_ctrl

/* verilog/tccoc_edge.sv */
// edge detector for one timer input pin with selectable valid edge
`include "tccoc_map.svh"
module tccoc_edge (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic pin_in,
    input wire logic [1:0] sel_in,
    output logic valid_out,
    output logic reverse_out
);
    tccoc_pkg::tccoc_edge_s st;
    tccoc_pkg::tccoc_edge_s next_st;
    logic rise;
    logic fall;

    always_comb begin
        next_st.prev = pin_in;
        rise = pin_in & ~st.prev;
        fall = ~pin_in & st.prev;
        valid_out = 1'h0;
        reverse_out = 1'h0;
        case (sel_in)
            `TCCOC_EDGE_FALL: begin
                valid_out = fall;
                reverse_out = rise;
            end
            `TCCOC_EDGE_RISE: begin
                valid_out = rise;
                reverse_out = fall;
            end
            // both edges leave no opposite edge
            `TCCOC_EDGE_BOTH: begin
                valid_out = rise | fall;
                reverse_out = 1'h0;
            end
            default: begin
                valid_out = 1'h0;
                reverse_out = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : tccoc_edge

/* verilog/tccoc_top.sv */
// timer capture/compare control and timer output logic with axi4-lite registers
//
// Our own choice: register access over AXI4-Lite.
`include "tccoc_map.svh"
module tccoc_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire tccoc_pkg::tccoc_axi_req_s axi_req_in,
    output tccoc_pkg::tccoc_axi_rsp_s axi_rsp_out,
    input wire logic edge_input_a_in,
    input wire logic edge_input_b_in,
    output logic wave_out_out,
    output logic match_a_irq_out,
    output logic match_b_irq_out
);
    tccoc_pkg::tccoc_state_s st;
    tccoc_pkg::tccoc_state_s next_st;
    tccoc_pkg::tccoc_reg_e wid;
    tccoc_pkg::tccoc_reg_e rid;
    logic a_edge;
    logic a_rev;
    logic b_edge;
    logic running;
    logic tick;
    logic a_match;
    logic b_match;
    logic cap_a;
    logic cap_b;
    logic ext_a;
    logic wr_go;
    logic ost_wr;
    logic lvl_wr;
    logic arm_set;
    logic inv_en;
    logic [15:0] rd_val;

    function automatic tccoc_pkg::tccoc_reg_e reg_decode(input logic [15:0] idx);
        case (idx)
            `TCCOC_IDX_TMC: reg_decode = tccoc_pkg::reg_tmc;
            `TCCOC_IDX_PRM: reg_decode = tccoc_pkg::reg_prm;
            `TCCOC_IDX_CRC: reg_decode = tccoc_pkg::reg_crc;
            `TCCOC_IDX_TOC: reg_decode = tccoc_pkg::reg_toc;
            `TCCOC_IDX_CCA: reg_decode = tccoc_pkg::reg_cca;
            `TCCOC_IDX_CCB: reg_decode = tccoc_pkg::reg_ccb;
            default: reg_decode = tccoc_pkg::reg_none;
        endcase
    endfunction : reg_decode

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [1:0] strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge16

    tccoc_edge u_edge_a (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pin_in(edge_input_a_in),
        .sel_in(st.prm[`TCCOC_PRM_AEDGE]),
        .valid_out(a_edge),
        .reverse_out(a_rev)
    );

    tccoc_edge u_edge_b (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pin_in(edge_input_b_in),
        .sel_in(st.prm[`TCCOC_PRM_BEDGE]),
        .valid_out(b_edge),
        .reverse_out()
    );

    always_comb begin
        next_st = st;
        wid = reg_decode(st.waddr);
        rid = reg_decode(axi_req_in.araddr[17:2]);
        running = st.run != `TCCOC_RUN_STOP;
        // count clock select
        case (st.prm[`TCCOC_PRM_CKS])
            `TCCOC_CKS_FULL: tick = running;
            `TCCOC_CKS_DIV4: tick = running & ((st.div & `TCCOC_DIV4_MASK) == `TCCOC_DIV4_MASK);
            `TCCOC_CKS_DIV256: tick = running & (st.div == `TCCOC_DIV256_MASK);
            default: tick = running & a_edge;
        endcase
        a_match = tick & ~st.crc[`TCCOC_CRC_AMODE] & (st.cnt == st.cca);
        b_match = tick & ~st.crc[`TCCOC_CRC_BMODE] & (st.cnt == st.ccb);
        cap_a = running & st.crc[`TCCOC_CRC_AMODE]
            & (st.crc[`TCCOC_CRC_ATRIG] ? a_rev : b_edge);
        ext_a = running & st.crc[`TCCOC_CRC_AMODE] & st.crc[`TCCOC_CRC_ATRIG] & b_edge;
        cap_b = running & st.crc[`TCCOC_CRC_BMODE] & a_edge;
        // read path
        case (rid)
            tccoc_pkg::reg_tmc: rd_val = {12'h000, st.run, 1'h0, st.ovf};
            tccoc_pkg::reg_prm: rd_val = {8'h00, st.prm};
            tccoc_pkg::reg_crc: rd_val = {13'h0000, st.crc};
            // trigger bits read as zero
            tccoc_pkg::reg_toc: rd_val = {8'h00, 2'h0, st.osel, st.invb, 2'h0, st.inva, st.toe};
            tccoc_pkg::reg_cca: rd_val = st.cca;
            tccoc_pkg::reg_ccb: rd_val = st.ccb;
            default: rd_val = `TCCOC_RST_16;
        endcase
        // axi write channel
        if (st.aw_rdy & axi_req_in.awvalid) begin
            next_st.aw_rdy = 1'h0;
            next_st.waddr = axi_req_in.awaddr[17:2];
        end
        if (st.w_rdy & axi_req_in.wvalid) begin
            next_st.w_rdy = 1'h0;
            next_st.wdata = axi_req_in.wdata[15:0];
            next_st.wstrb = axi_req_in.wstrb[1:0];
        end
        wr_go = ~st.aw_rdy & ~st.w_rdy & ~st.bvalid;
        if (wr_go) begin
            next_st.bvalid = 1'h1;
            next_st.bresp = (wid == tccoc_pkg::reg_none) ? `TCCOC_RESP_SLVERR : `TCCOC_RESP_OKAY;
        end
        if (st.bvalid & axi_req_in.bready) begin
            next_st.bvalid = 1'h0;
            next_st.aw_rdy = 1'h1;
            next_st.w_rdy = 1'h1;
        end
        // axi read channel
        if (st.ar_rdy & axi_req_in.arvalid) begin
            next_st.ar_rdy = 1'h0;
            next_st.rvalid = 1'h1;
            next_st.rdata = rd_val;
            next_st.rresp = (rid == tccoc_pkg::reg_none) ? `TCCOC_RESP_SLVERR : `TCCOC_RESP_OKAY;
        end
        if (st.rvalid & axi_req_in.rready) begin
            next_st.rvalid = 1'h0;
            next_st.ar_rdy = 1'h1;
        end
        // register writes
        ost_wr = 1'h0;
        lvl_wr = 1'h0;
        if (wr_go & st.wstrb[0]) begin
            case (wid)
                tccoc_pkg::reg_tmc: begin
                    next_st.run = st.wdata[`TCCOC_TMC_RUN];
                    next_st.ovf = st.wdata[`TCCOC_TMC_OVF];
                end
                tccoc_pkg::reg_prm: next_st.prm = st.wdata[7:0] & `TCCOC_PRM_MASK;
                tccoc_pkg::reg_crc: next_st.crc = st.wdata[2:0];
                tccoc_pkg::reg_toc: begin
                    next_st.osel = st.wdata[`TCCOC_TOC_OSEL];
                    next_st.invb = st.wdata[`TCCOC_TOC_INVB];
                    next_st.inva = st.wdata[`TCCOC_TOC_INVA];
                    next_st.toe = st.wdata[`TCCOC_TOC_TOE];
                    ost_wr = st.wdata[`TCCOC_TOC_OST];
                    lvl_wr = st.wdata[`TCCOC_TOC_LVS] ^ st.wdata[`TCCOC_TOC_LVR];
                end
                default: begin
                end
            endcase
        end
        if (wr_go & (wid == tccoc_pkg::reg_cca)) begin
            next_st.cca = merge16(st.cca, st.wdata, st.wstrb);
        end
        if (wr_go & (wid == tccoc_pkg::reg_ccb)) begin
            next_st.ccb = merge16(st.ccb, st.wdata, st.wstrb);
        end
        // prescaler and counter
        next_st.div = running ? 8'(st.div + 8'h01) : `TCCOC_RST_8;
        if (!running) begin
            next_st.cnt = `TCCOC_RST_16;
            next_st.ovf = 1'h0;
        end else if (ost_wr) begin
            next_st.cnt = `TCCOC_RST_16;
        end else if ((st.run == `TCCOC_RUN_CLR_EDGE) & a_edge) begin
            next_st.cnt = `TCCOC_RST_16;
        end else if (tick) begin
            if ((st.run == `TCCOC_RUN_CLR_MATCH) & a_match) begin
                next_st.cnt = `TCCOC_RST_16;
            end else begin
                next_st.cnt = 16'(st.cnt + 16'h0001);
                if (st.cnt == `TCCOC_CNT_TOP) begin
                    next_st.ovf = 1'h1;
                end
            end
        end
        // captures win over a bus write in the same cycle
        if (cap_a) begin
            next_st.cca = st.cnt;
        end
        if (cap_b) begin
            next_st.ccb = st.cnt;
        end
        next_st.irq_a = a_match | cap_a | ext_a;
        next_st.irq_b = b_match | cap_b;
        // one-shot arming
        arm_set = st.osel & (st.run != `TCCOC_RUN_CLR_MATCH)
            & (ost_wr | ((st.run == `TCCOC_RUN_CLR_EDGE) & a_edge));
        inv_en = ~st.osel | st.armed;
        if (!running | ~st.osel) begin
            next_st.armed = 1'h0;
        end else if (arm_set) begin
            next_st.armed = 1'h1;
        end else if (b_match) begin
            next_st.armed = 1'h0;
        end
        // output level
        if (lvl_wr) begin
            next_st.lvl = st.wdata[`TCCOC_TOC_LVS];
        end else if (inv_en) begin
            next_st.lvl = st.lvl ^ (a_match & st.inva) ^ (b_match & st.invb);
        end
        next_st.wave = next_st.toe & next_st.lvl;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
            st.aw_rdy <= 1'h1;
            st.w_rdy <= 1'h1;
            st.ar_rdy <= 1'h1;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        axi_rsp_out.awready = st.aw_rdy;
        axi_rsp_out.wready = st.w_rdy;
        axi_rsp_out.bvalid = st.bvalid;
        axi_rsp_out.bresp = st.bresp;
        axi_rsp_out.arready = st.ar_rdy;
        axi_rsp_out.rvalid = st.rvalid;
        axi_rsp_out.rdata = {16'h0000, st.rdata};
        axi_rsp_out.rresp = st.rresp;
        wave_out_out = st.wave;
        match_a_irq_out = st.irq_a;
        match_b_irq_out = st.irq_b;
    end

    chk_toc_trig_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.ar_rdy & axi_req_in.arvalid & (rid == tccoc_pkg::reg_toc)) |=> !st.rdata[6])
        else $error("one-shot trigger bit read back as one");

    chk_level_read_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.ar_rdy & axi_req_in.arvalid & (rid == tccoc_pkg::reg_toc))
        |=> (st.rdata[3:2] == 2'h0))
        else $error("level trigger bits read back non-zero");

    chk_out_disabled_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !st.toe |-> !wave_out_out)
        else $error("timer output high while disabled");

    chk_b_match_invert: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (b_match & st.invb & ~st.osel & ~a_match & ~lvl_wr) |=> (st.lvl != $past(st.lvl)))
        else $error("b match did not invert output");

    chk_a_match_invert: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (a_match & st.inva & ~st.osel & ~b_match & ~lvl_wr) |=> (st.lvl != $past(st.lvl)))
        else $error("a match did not invert output");

    chk_match_irqs: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (b_match & ~st.invb) |=> match_b_irq_out ##1 !match_b_irq_out || $past(b_match | cap_b))
        else $error("b match interrupt missing");

    chk_capture_b_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
        cap_b |=> (st.ccb == $past(st.cnt)) && match_b_irq_out)
        else $error("capture b did not load counter");

    chk_capture_a_b_edge: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (running & st.crc[`TCCOC_CRC_AMODE] & ~st.crc[`TCCOC_CRC_ATRIG] & b_edge)
        |=> (st.cca == $past(st.cnt)) && match_a_irq_out)
        else $error("capture a on b edge failed");

    chk_both_no_reverse: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.prm[`TCCOC_PRM_AEDGE] == `TCCOC_EDGE_BOTH) |-> !a_rev)
        else $error("reverse edge seen with both edges");

    chk_stop_clears: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.run == `TCCOC_RUN_STOP) ##1 (st.run == `TCCOC_RUN_STOP) |-> (st.cnt == 16'h0000))
        else $error("counter not cleared while stopped");

    chk_trigger_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ost_wr & running) |=> (st.cnt == 16'h0000))
        else $error("one-shot trigger did not clear counter");

    chk_level_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (lvl_wr & ~st.wdata[`TCCOC_TOC_LVS])
        |=> !st.lvl ##1 ((st.lvl == $past(st.lvl)) || $past(inv_en & (a_match | b_match))))
        else $error("level reset did not force low");

    chk_no_oneshot_match: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.run == `TCCOC_RUN_CLR_MATCH) & ~st.armed |=> !st.armed)
        else $error("one-shot armed in match-clear mode");

    chk_a_match_irq: assert property (@(posedge clk_in) disable iff (!nrst_in)
        a_match |=> match_a_irq_out)
        else $error("a match interrupt missing");

    chk_b_match_irq: assert property (@(posedge clk_in) disable iff (!nrst_in)
        b_match |=> match_b_irq_out)
        else $error("b match interrupt missing after match");

    chk_capture_a_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
        cap_a |=> (st.cca == $past(st.cnt)) && match_a_irq_out)
        else $error("capture a did not load counter");

    chk_level_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (lvl_wr & st.wdata[`TCCOC_TOC_LVS]) |=> st.lvl)
        else $error("level set did not force high");

    chk_free_count_up: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ((st.run == `TCCOC_RUN_FREE) & tick & ~ost_wr)
        |=> (st.cnt == 16'($past(st.cnt) + 16'h0001)))
        else $error("free-running counter did not step");

    chk_match_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ((st.run == `TCCOC_RUN_CLR_MATCH) & a_match) |=> (st.cnt == 16'h0000))
        else $error("counter not cleared on a match");

    chk_edge_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ((st.run == `TCCOC_RUN_CLR_EDGE) & a_edge) |=> (st.cnt == 16'h0000))
        else $error("counter not cleared on input a edge");

    chk_oneshot_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (st.osel & ~st.armed & ~lvl_wr) |=> $stable(st.lvl))
        else $error("output moved while one-shot idle");

    chk_oneshot_arm: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ost_wr & st.osel & running & (st.run != `TCCOC_RUN_CLR_MATCH))
        |=> st.armed)
        else $error("one-shot trigger did not arm pulse");
endmodule : tccoc_top
